// ### src/tof_i2c_target.sv
// two-wire bus target giving access to the internal register space
//
// What this block does
// - 7-bit addressed target at standard, fast and fast-plus speeds
// - holds an 8-bit pointer selecting the register being accessed
// - pointer advances by one after each data byte, read or write
// - pointer keeps its value across STOP and bus release
// - read without pointer byte continues from last location plus one
// - device acknowledges on the ninth clock after each received byte, except an address byte for another target
// - host ends read with not-acknowledge; device then stops driving data
// - after power-up the device answers at address 0x41
// - target address may be reprogrammed any time, for later transfers
// - in standby only traffic addressed to the device wakes it
// - enable pin low clears all state including pointer and address
// - interrupt output is open-drain, only pulling low when asserted
`timescale 1ns/1ps
`default_nettype none
`include "tof_i2c_defs.svh"

module tof_i2c_target #(
   parameter int PTR_W = `PTR_W_DEF
) (
   // clock and reset
   input  wire logic                   CLOCK_I,
   input  wire logic                   RST_I,
   input  wire logic                   EN_I,
   // bus pins
   input  wire logic                   SCL_I,
   input  wire logic                   SDA_I,
   output logic                        SDA_O,
   output logic                        SDA_OE_O,
   // interrupt pin
   input  wire logic                   IRQ_I,
   output logic                        INT_O,
   output logic                        INT_OE_O,
   // address programming and wake
   input  wire logic                   ADDR_LOAD_I,
   input  wire logic [`TGT_ADDR_W-1:0] ADDR_NEW_I,
   output logic                        WAKE_O,
   // register space
   output logic [PTR_W-1:0]            REG_RADDR_O,
   output logic                        REG_RD_O,
   input  wire logic [7:0]             REG_RDATA_I,
   output logic                        REG_WR_O,
   output logic [PTR_W-1:0]            REG_WADDR_O,
   output logic [7:0]                  REG_WDATA_O
);

   ////////////////////////////////////////////////////////////////////////
   // state
   tof_i2c_pkg::state_e    st;
   logic                   clr;
   logic                   scl_q;
   logic                   sda_q;
   logic [2:0]             cnt;
   logic [6:0]             sh;
   logic [7:0]             tx;
   logic [PTR_W-1:0]       ptr;
   logic [`TGT_ADDR_W-1:0] dev_addr;
   logic                   rw;
   logic                   first;
   logic                   phase;
   logic                   host_ack;
   logic                   sda_oe;
   logic                   int_oe;
   logic                   wr;
   logic [PTR_W-1:0]       waddr;
   logic [7:0]             wdata;

   ////////////////////////////////////////////////////////////////////////
   // decoding
   wire scl_rise  = !scl_q && SCL_I;
   wire scl_fall  = scl_q && !SCL_I;
   wire start_c   = scl_q && SCL_I && sda_q && !SDA_I;
   wire stop_c    = scl_q && SCL_I && !sda_q && SDA_I;
   wire last_bit  = (cnt == `LAST_BIT);
   wire [7:0] rx_byte = {sh, SDA_I};
   wire in_addr   = (st == tof_i2c_pkg::ST_ADDR);
   wire addr_end  = in_addr && scl_rise && last_bit;
   wire addr_hit  = addr_end && (sh == dev_addr);
   wire addr_miss = addr_end && (sh != dev_addr);
   wire wrx_end   = (st == tof_i2c_pkg::ST_WRX) && scl_rise && last_bit;
   wire ptr_load  = wrx_end && first;
   wire data_wr   = wrx_end && !first;
   wire aack_end  = (st == tof_i2c_pkg::ST_AACK) && phase && scl_fall;
   wire mack_end  = (st == tof_i2c_pkg::ST_MACK) && phase && scl_fall;
   wire ld_tx     = (aack_end && rw) || (mack_end && host_ack);
   wire ptr_inc   = ld_tx || data_wr;
   wire [PTR_W-1:0] ptr_next = ptr + PTR_W'(1);
   wire any_event = start_c || stop_c || scl_rise || scl_fall;

   assign clr         = RST_I || !EN_I;
   assign SDA_O       = 1'b0;
   assign SDA_OE_O    = sda_oe;
   assign INT_O       = 1'b0;
   assign INT_OE_O    = int_oe;
   assign WAKE_O      = addr_hit;
   assign REG_RADDR_O = ptr;
   assign REG_RD_O    = ld_tx;
   assign REG_WR_O    = wr;
   assign REG_WADDR_O = waddr;
   assign REG_WDATA_O = wdata;

   ////////////////////////////////////////////////////////////////////////
   // pin sampling, interrupt and address register
   always_ff @(posedge CLOCK_I) begin
      if (clr) begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         int_oe   <= 1'b0;
         dev_addr <= `TGT_ADDR_DEF;
      end else begin
         scl_q  <= SCL_I;
         sda_q  <= SDA_I;
         int_oe <= IRQ_I;
         if (ADDR_LOAD_I) begin
            dev_addr <= ADDR_NEW_I;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register pointer and write strobe
   always_ff @(posedge CLOCK_I) begin
      if (clr) begin
         ptr   <= `PTR_RST;
         wr    <= 1'b0;
         waddr <= `PTR_RST;
         wdata <= 8'h00;
      end else begin
         wr <= data_wr;
         if (ptr_load) begin
            ptr <= rx_byte[PTR_W-1:0];
         end else if (ptr_inc) begin
            ptr <= ptr_next;
         end
         if (data_wr) begin
            waddr <= ptr;
            wdata <= rx_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus sequencer
   always_ff @(posedge CLOCK_I) begin
      if (clr) begin
         st       <= tof_i2c_pkg::ST_IDLE;
         cnt      <= 3'h0;
         sh       <= 7'h00;
         tx       <= 8'h00;
         rw       <= 1'b0;
         first    <= 1'b0;
         phase    <= 1'b0;
         host_ack <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (start_c) begin
         st     <= tof_i2c_pkg::ST_ADDR;
         cnt    <= 3'h0;
         first  <= 1'b1;
         sda_oe <= 1'b0;
      end else if (stop_c) begin
         st     <= tof_i2c_pkg::ST_IDLE;
         sda_oe <= 1'b0;
      end else if (any_event) begin
         unique case (st)
            tof_i2c_pkg::ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            tof_i2c_pkg::ST_ADDR,
            tof_i2c_pkg::ST_WRX: begin
               if (scl_rise) begin
                  sh  <= rx_byte[6:0];
                  cnt <= cnt + 3'h1;
               end
               if (addr_miss) begin
                  st <= tof_i2c_pkg::ST_IDLE;
               end else if (addr_hit) begin
                  st    <= tof_i2c_pkg::ST_AACK;
                  rw    <= SDA_I;
                  phase <= 1'b0;
               end else if (wrx_end) begin
                  st    <= tof_i2c_pkg::ST_WACK;
                  first <= 1'b0;
                  phase <= 1'b0;
               end
            end
            tof_i2c_pkg::ST_AACK,
            tof_i2c_pkg::ST_WACK: begin
               if (scl_fall && !phase) begin
                  sda_oe <= 1'b1;
                  phase  <= 1'b1;
               end else if (ld_tx) begin
                  sda_oe <= !REG_RDATA_I[7];
                  tx     <= {REG_RDATA_I[6:0], 1'b0};
                  cnt    <= 3'h0;
                  st     <= tof_i2c_pkg::ST_TX;
               end else if (scl_fall) begin
                  sda_oe <= 1'b0;
                  cnt    <= 3'h0;
                  st     <= tof_i2c_pkg::ST_WRX;
               end
            end
            tof_i2c_pkg::ST_TX: begin
               if (scl_rise) begin
                  cnt <= cnt + 3'h1;
                  if (last_bit) begin
                     st    <= tof_i2c_pkg::ST_MACK;
                     phase <= 1'b0;
                  end
               end else if (scl_fall) begin
                  sda_oe <= !tx[7];
                  tx     <= {tx[6:0], 1'b0};
               end
            end
            tof_i2c_pkg::ST_MACK: begin
               if (scl_fall && !phase) begin
                  sda_oe <= 1'b0;
                  phase  <= 1'b1;
               end else if (scl_rise) begin
                  host_ack <= !SDA_I;
               end else if (ld_tx) begin
                  sda_oe <= !REG_RDATA_I[7];
                  tx     <= {REG_RDATA_I[6:0], 1'b0};
                  cnt    <= 3'h0;
                  st     <= tof_i2c_pkg::ST_TX;
               end else if (scl_fall) begin
                  sda_oe <= 1'b0;
                  st     <= tof_i2c_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (clr);

   a_start_addr: assert property (
      start_c |=> st == tof_i2c_pkg::ST_ADDR)
      else $error("start not followed by address phase");
   a_ptr_wrap: assert property (
      ptr_inc && (&ptr) |=> ptr == '0)
      else $error("pointer did not wrap");
   a_ptr_advance: assert property (
      ptr_inc |=> ptr == $past(ptr) + PTR_W'(1))
      else $error("pointer did not advance by one");
   a_ptr_keep: assert property (
      stop_c |=> ptr == $past(ptr))
      else $error("pointer changed at stop");
   a_ptr_hold: assert property (
      !ptr_inc && !ptr_load |=> ptr == $past(ptr))
      else $error("pointer moved without a byte");
   a_read_cont: assert property (
      ld_tx |=> st == tof_i2c_pkg::ST_TX
      && SDA_OE_O == !$past(REG_RDATA_I[7]))
      else $error("read not served from pointer");
   a_ack_drive: assert property (
      (st == tof_i2c_pkg::ST_WACK || st == tof_i2c_pkg::ST_AACK)
      && !phase && scl_fall && !start_c && !stop_c
      |=> SDA_OE_O && phase)
      else $error("no acknowledge on ninth clock");
   a_nack_release: assert property (
      mack_end && !host_ack && !start_c && !stop_c
      |=> !SDA_OE_O && st == tof_i2c_pkg::ST_IDLE)
      else $error("data still driven after host nack");
   a_addr_reset: assert property (
      @(posedge CLOCK_I) disable iff (1'b0)
      clr |=> dev_addr == `TGT_ADDR_DEF
      && ptr == `PTR_RST && !SDA_OE_O)
      else $error("enable low did not clear state");
   a_addr_load: assert property (
      ADDR_LOAD_I |=> dev_addr == $past(ADDR_NEW_I))
      else $error("address not reprogrammed");
   a_foreign_addr: assert property (
      addr_miss |=> st == tof_i2c_pkg::ST_IDLE ##1 !SDA_OE_O)
      else $error("foreign address acted on");
   a_wake_match: assert property (
      WAKE_O |=> st == tof_i2c_pkg::ST_AACK)
      else $error("wake without address acknowledge");
   a_int_drain: assert property (
      IRQ_I |=> INT_OE_O && !INT_O)
      else $error("interrupt not pulled low");
   a_int_release: assert property (
      !IRQ_I |=> !INT_OE_O)
      else $error("interrupt not released");

   c_write_byte: cover property (data_wr);
   c_read_two: cover property (ld_tx ##[1:400] ld_tx);
   c_host_nack: cover property (mack_end && !host_ack);
   c_foreign: cover property (addr_miss);
   c_ptr_wrap: cover property (ptr_inc && (&ptr));

endmodule : tof_i2c_target

`default_nettype wire

// ### src/tof_i2c_defs.svh
// constants of the two-wire register access port
`ifndef TOF_I2C_DEFS_SVH
`define TOF_I2C_DEFS_SVH

// target address after power-up or enable
`define TGT_ADDR_DEF 7'h41
// address and pointer widths
`define TGT_ADDR_W   7
`define PTR_W_DEF    8
// pointer value after reset
`define PTR_RST      8'h00
// bit index of the last bit of a byte
`define LAST_BIT     3'h7

`endif

// ### src/tof_i2c_pkg.sv
// types of the two-wire register access port
package tof_i2c_pkg;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_ADDR = 7'b0000010,
      ST_AACK = 7'b0000100,
      ST_WRX  = 7'b0001000,
      ST_WACK = 7'b0010000,
      ST_TX   = 7'b0100000,
      ST_MACK = 7'b1000000
   } state_e;

endpackage : tof_i2c_pkg

// ### bench/tof_i2c_host.sv
// bus controller model driving the two-wire link toward the target
`timescale 1ns/1ps
`default_nettype none

module tof_i2c_host (
   // clock
   input  wire logic clk_i,
   // bus pins
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_oe_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // one half() step is four system clocks; scl stays high one step and low two
   task automatic half();
      repeat (4) @(posedge clk_i);
      #1;
   endtask : half
   task automatic bit_x(input logic v, output logic r);
      half();
      sda_oe_o = !v;
      half();
      scl_o = 1'b1;
      half();
      r = sda_i;
      scl_o = 1'b0;
   endtask : bit_x
   // start, or repeated start when re is set
   task automatic start(input logic re);
      if (re) begin
         half();
         sda_oe_o = 1'b0;
         half();
         scl_o = 1'b1;
      end
      half();
      sda_oe_o = 1'b1;
      half();
      scl_o = 1'b0;
   endtask : start
   task automatic stop();
      half();
      sda_oe_o = 1'b1;
      half();
      scl_o = 1'b1;
      half();
      sda_oe_o = 1'b0;
      half();
   endtask : stop
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = !r;
   endtask : send
   task automatic recv(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         b[i] = r;
      end
      bit_x(last, r);
   endtask : recv
endmodule : tof_i2c_host

`default_nettype wire

// ### bench/tof_i2c_target_test.sv
// self-checking bench of the two-wire register access port
`timescale 1ns/1ps
`default_nettype none

module tof_i2c_target_test;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            en = 1'b1;
   logic            irq = 1'b0;
   logic            ld = 1'b0;
   logic [6:0]      new_a = 7'h00;
   logic [7:0]      lw_a, lw_d, ep;
   logic [7:0]      mem [256];
   logic [7:0]      sh [256];
   int              err_total = 0;
   int              num_checks = 0;
   int              n_wr = 0;
   int              n_wk = 0;
   int              n_rd = 0;
   int              seed = 32'h4a9a;
   wire logic       scl, h_oe, sda_o, sda_oe, int_o, int_oe, wake, rd, wr;
   wire logic [7:0] raddr, waddr, wdata, rdata;
   wire logic       sda = !(h_oe || sda_oe);

   always #20 clk = !clk;
   assign rdata = mem[raddr];

   tof_i2c_target tof_i2c_target_inst (
      .CLOCK_I(clk), .RST_I(rst), .EN_I(en), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE_O(sda_oe), .IRQ_I(irq), .INT_O(int_o),
      .INT_OE_O(int_oe), .ADDR_LOAD_I(ld), .ADDR_NEW_I(new_a),
      .WAKE_O(wake), .REG_RADDR_O(raddr), .REG_RD_O(rd),
      .REG_RDATA_I(rdata), .REG_WR_O(wr), .REG_WADDR_O(waddr),
      .REG_WDATA_O(wdata));
   tof_i2c_host tof_i2c_host_inst (
      .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

   // register space and pulse counters
   always @(posedge clk) begin
      if (wr === 1'b1) begin
         mem[waddr] <= wdata;
         lw_a <= waddr;
         lw_d <= wdata;
         n_wr <= n_wr + 1;
      end
      if (wake === 1'b1) n_wk <= n_wk + 1;
      if (rd === 1'b1) n_rd <= n_rd + 1;
   end
   //////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] iv(input int i);
      return 8'(i) ^ 8'hC3;
   endfunction : iv
   task automatic chk(input string nm, input logic [7:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic adr(input logic [6:0] a, input logic rw, ok);
      logic ack;
      int w;
      w = n_wk;
      tof_i2c_host_inst.send({a, rw}, ack);
      chk("addr ack", 8'(ok), 8'(ack));
      chk("wake", 8'(ok), 8'(n_wk - w));
   endtask : adr
   task automatic wrt(input logic [6:0] a, input logic ok,
                      input logic [7:0] p, input int n);
      logic ack;
      logic [7:0] d;
      int c;
      c = n_wr;
      tof_i2c_host_inst.start(1'b0);
      adr(a, 1'b0, ok);
      tof_i2c_host_inst.send(p, ack);
      chk("ptr ack", 8'(ok), 8'(ack));
      if (ok) ep = p;
      repeat (n) begin
         d = 8'($random(seed));
         tof_i2c_host_inst.send(d, ack);
         chk("data ack", 8'(ok), 8'(ack));
         if (ok) begin
            chk("wr addr", ep, lw_a);
            chk("wr data", d, lw_d);
            sh[ep] = d;
            ep++;
         end
      end
      tof_i2c_host_inst.stop();
      chk("wr count", 8'(ok ? n : 0), 8'(n_wr - c));
   endtask : wrt
   task automatic rdt(input logic [6:0] a, input logic sp,
                      input logic [7:0] p, input int n);
      logic ack;
      logic [7:0] d;
      int c;
      c = n_rd;
      tof_i2c_host_inst.start(1'b0);
      if (sp) begin
         adr(a, 1'b0, 1'b1);
         tof_i2c_host_inst.send(p, ack);
         ep = p;
         tof_i2c_host_inst.start(1'b1);
      end
      adr(a, 1'b1, 1'b1);
      for (int i = 1; i <= n; i++) begin
         tof_i2c_host_inst.recv(i == n, d);
         chk("rd data", sh[ep], d);
         ep++;
      end
      repeat (3) @(posedge clk);
      #1;
      chk("released", 8'h00, 8'(sda_oe));
      chk("rd count", 8'(n), 8'(n_rd - c));
      chk("sda level", 8'h00, 8'(sda_o));
      tof_i2c_host_inst.stop();
   endtask : rdt
   task automatic results();
      if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   //////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = iv(i);
         sh[i] = iv(i);
      end
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      wrt(7'h41, 1'b1, 8'h10, 3);
      rdt(7'h41, 1'b1, 8'h10, 3);
      rdt(7'h41, 1'b0, 8'h00, 2);
      wrt(7'h41, 1'b1, 8'hFE, 3);
      rdt(7'h41, 1'b1, 8'hFF, 2);
      wrt(7'h22, 1'b0, 8'h00, 1);
      new_a = 7'h2A;
      ld = 1'b1;
      @(posedge clk);
      #1;
      ld = 1'b0;
      wrt(7'h41, 1'b0, 8'h00, 1);
      repeat (4) begin
         wrt(7'h2A, 1'b1, 8'($random(seed)), 1 + ($random(seed) & 3));
         rdt(7'h2A, 1'b1, 8'($random(seed)), 3);
      end
      en = 1'b0;
      @(posedge clk);
      #1;
      en = 1'b1;
      ep = 8'h00;
      rdt(7'h41, 1'b0, 8'h00, 2);
      new_a = 7'h35;
      ld = 1'b1;
      @(posedge clk);
      #1;
      ld = 1'b0;
      wrt(7'h35, 1'b1, 8'h40, 2);
      irq = 1'b1;
      chk("int idle", 8'h00, 8'(int_oe));
      @(posedge clk);
      #1;
      chk("int drive", 8'h01, 8'(int_oe));
      chk("int level", 8'h00, 8'(int_o));
      irq = 1'b0;
      @(posedge clk);
      #1;
      chk("int free", 8'h00, 8'(int_oe));
      results();
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      results();
   end
endmodule : tof_i2c_target_test

`default_nettype wire
